/* hw/window_delay_regs.sv */
// module: APB register bank for the readout window and frame/line gaps
//
// Register access over APB was left to the implementer.
module window_delay_regs #(
  parameter int PADDR_WIDTH = 8
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PADDR_WIDTH-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic frameStart,
  output logic [10:0] firstRowAddress,
  output logic [10:0] lastRowAddress,
  output logic [10:0] firstColumnAddress,
  output logic [10:0] lastColumnAddress,
  output logic [14:0] frameGap,
  output logic [7:0] lineGapHigh,
  output logic [7:0] lineGapLow,
  output logic settingsPending,
  output logic settingsApplied
);

  localparam int NR = window_delay_pkg::NUM_REGS;
  localparam int W = window_delay_pkg::REG_WIDTH;
  localparam int LB = window_delay_pkg::LOW_BITS;

  // the highest byte address, that of the status word, needs eight address bits
  if (PADDR_WIDTH < 8 || PADDR_WIDTH > 32) begin : g_badAddr
    $error("window_delay_regs: PADDR_WIDTH must be 8 to 32");
  end

  // bus phase decode
  logic setupPhase;
  logic accessPhase;
  assign setupPhase = psel & ~penable;
  assign accessPhase = psel & penable;

  // address decode of the buffered registers
  logic [NR-1:0] hit;
  genvar gi;
  for (gi = 0; gi < NR; gi++) begin : g_decode
    assign hit[gi] = paddr ==
      PADDR_WIDTH'(window_delay_pkg::byte_addr(window_delay_pkg::REG_INDEX[gi]));
  end

  // decode of the update control and status words
  logic ctrlHit;
  logic statusHit;
  logic mapped;
  assign ctrlHit = paddr ==
    PADDR_WIDTH'(window_delay_pkg::byte_addr(window_delay_pkg::IDX_UPDATE_CTRL));
  assign statusHit = paddr ==
    PADDR_WIDTH'(window_delay_pkg::byte_addr(window_delay_pkg::IDX_UPDATE_STATUS));
  assign mapped = (|hit) | ctrlHit | statusHit;

  // a write lands at the access edge; only byte lane 0 carries data
  logic writeStrobe;
  logic [NR-1:0] cellWrite;
  logic anyCellWrite;
  assign writeStrobe = accessPhase & pwrite & pstrb[0];
  assign cellWrite = writeStrobe ? hit : '0;
  assign anyCellWrite = |cellWrite;

  // freeze lets software stage a full window over several frames
  logic freeze;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      freeze <= 1'b0;
    end else if (writeStrobe && ctrlHit) begin
      freeze <= pwdata[window_delay_pkg::CTRL_FREEZE_BIT];
    end
  end

  // all cells commit in the same cycle at the frame boundary
  logic commit;
  assign commit = frameStart & ~freeze;

  // holding and active copies
  logic [W-1:0] holdVal [NR];
  logic [W-1:0] activeVal [NR];
  for (gi = 0; gi < NR; gi++) begin : g_cell
    buffered_reg_cell #(
      .WIDTH(W),
      .RESET_VALUE(window_delay_pkg::REG_RESET[gi]),
      .KEEP_MASK(window_delay_pkg::REG_KEEP[gi])
    ) u_cell (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .writeEn(cellWrite[gi]),
      .writeData(pwdata[W-1:0]),
      .commit(commit),
      .holdValue(holdVal[gi]),
      .activeValue(activeVal[gi])
    );
  end

  // pending: a write landing in the commit cycle keeps it set
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      settingsPending <= 1'b0;
    end else if (anyCellWrite) begin
      settingsPending <= 1'b1;
    end else if (commit) begin
      settingsPending <= 1'b0;
    end
  end

  // one-cycle mark that new settings are live
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      settingsApplied <= 1'b0;
    end else begin
      settingsApplied <= commit;
    end
  end

  // read mux returns the holding copies, which is what software wrote
  logic [W-1:0] readMux;
  always_comb begin
    readMux = '0;
    for (int i = 0; i < NR; i++) begin
      if (hit[i]) begin
        readMux = holdVal[i];
      end
    end
    if (ctrlHit) begin
      readMux[window_delay_pkg::CTRL_FREEZE_BIT] = freeze;
    end
    if (statusHit) begin
      readMux[window_delay_pkg::STATUS_PENDING_BIT] = settingsPending;
      readMux[window_delay_pkg::STATUS_FROZEN_BIT] = freeze;
    end
  end

  // read data is captured in the setup cycle so it stands through access
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      prdata <= 32'h0000_0000;
    end else if (setupPhase && !pwrite) begin
      prdata <= 32'(readMux);
    end
  end

  // error flag is captured at setup as well
  logic decodeErr;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      decodeErr <= 1'b0;
    end else if (setupPhase) begin
      decodeErr <= ~mapped;
    end
  end

  // zero-wait slave: every access completes in its first access cycle
  assign pready = 1'b1;
  assign pslverr = accessPhase & decodeErr;

  // window addresses assembled from active high and low bits
  assign firstRowAddress = {activeVal[window_delay_pkg::S_ROW_START],
    activeVal[window_delay_pkg::S_ROW_LOW][window_delay_pkg::ROW_START_LOW_POS +: LB]};
  assign lastRowAddress = {activeVal[window_delay_pkg::S_ROW_END],
    activeVal[window_delay_pkg::S_ROW_LOW][window_delay_pkg::ROW_END_LOW_POS +: LB]};
  assign firstColumnAddress = {activeVal[window_delay_pkg::S_COL_START],
    activeVal[window_delay_pkg::S_COL_LOW][window_delay_pkg::COL_START_LOW_POS],
    window_delay_pkg::COL_START_FIXED};
  assign lastColumnAddress = {activeVal[window_delay_pkg::S_COL_END],
    activeVal[window_delay_pkg::S_COL_LOW][window_delay_pkg::COL_END_LOW_POS +: LB]};

  // gaps; an over-range frame gap cannot arise, the field is only 15 bits
  assign frameGap = {activeVal[window_delay_pkg::S_FRAME_HIGH],
    activeVal[window_delay_pkg::S_FRAME_LOW][window_delay_pkg::FRAME_LOW_BITS-1:0]};
  assign lineGapHigh = activeVal[window_delay_pkg::S_LINE_HIGH];
  assign lineGapLow = activeVal[window_delay_pkg::S_LINE_LOW];

  // checks on the assembled outputs

  property p_rowStart;
    @(posedge ref_clk) disable iff (!resetn)
      commit |=> firstRowAddress[10:3] == $past(holdVal[window_delay_pkg::S_ROW_START]);
  endproperty
  a_rowStart: assert property (p_rowStart)
    else $error("first row high bits wrong after commit");

  property p_rowStartLow;
    @(posedge ref_clk) disable iff (!resetn)
      commit |=> firstRowAddress[2:0] == $past(holdVal[window_delay_pkg::S_ROW_LOW][5:3]);
  endproperty
  a_rowStartLow: assert property (p_rowStartLow)
    else $error("first row low bits wrong after commit");

  property p_rowEnd;
    @(posedge ref_clk) disable iff (!resetn)
      commit |=> lastRowAddress[10:3] == $past(holdVal[window_delay_pkg::S_ROW_END]);
  endproperty
  a_rowEnd: assert property (p_rowEnd)
    else $error("last row high bits wrong after commit");

  property p_rowEndLow;
    @(posedge ref_clk) disable iff (!resetn)
      commit |=> lastRowAddress[2:0] == $past(holdVal[window_delay_pkg::S_ROW_LOW][2:0]);
  endproperty
  a_rowEndLow: assert property (p_rowEndLow)
    else $error("last row low bits wrong after commit");

  property p_colStart;
    @(posedge ref_clk) disable iff (!resetn)
      commit |=> firstColumnAddress[10:3] == $past(holdVal[window_delay_pkg::S_COL_START])
        && firstColumnAddress[2] == $past(holdVal[window_delay_pkg::S_COL_LOW][5]);
  endproperty
  a_colStart: assert property (p_colStart)
    else $error("first column bits wrong after commit");

  property p_colAligned;
    @(posedge ref_clk) disable iff (!resetn)
      firstColumnAddress[1:0] == 2'h0;
  endproperty
  a_colAligned: assert property (p_colAligned)
    else $error("first column not a multiple of four");

  property p_colEnd;
    @(posedge ref_clk) disable iff (!resetn)
      commit |=> lastColumnAddress == $past({holdVal[window_delay_pkg::S_COL_END],
        holdVal[window_delay_pkg::S_COL_LOW][2:0]});
  endproperty
  a_colEnd: assert property (p_colEnd)
    else $error("last column wrong after commit");

  property p_frameGap;
    @(posedge ref_clk) disable iff (!resetn)
      commit |=> frameGap == $past({holdVal[window_delay_pkg::S_FRAME_HIGH],
        holdVal[window_delay_pkg::S_FRAME_LOW][6:0]});
  endproperty
  a_frameGap: assert property (p_frameGap)
    else $error("frame gap wrong after commit");

  property p_lineGap;
    @(posedge ref_clk) disable iff (!resetn)
      commit |=> lineGapHigh == $past(holdVal[window_delay_pkg::S_LINE_HIGH]);
  endproperty
  a_lineGap: assert property (p_lineGap)
    else $error("line gap high bits wrong after commit");

  // a write, one idle cycle, then a read of the same word returns the masked value
  property p_readBack;
    @(posedge ref_clk) disable iff (!resetn)
      (writeStrobe && hit[window_delay_pkg::S_ROW_LOW]) ##2
        (setupPhase && !pwrite && hit[window_delay_pkg::S_ROW_LOW])
      |=> prdata == 32'($past(pwdata[7:0], 3)
        & window_delay_pkg::REG_KEEP[window_delay_pkg::S_ROW_LOW]);
  endproperty
  a_readBack: assert property (p_readBack)
    else $error("read back of row low bits wrong");

  // no mixing: outside a commit every window and gap output stands
  property p_noMix;
    @(posedge ref_clk) disable iff (!resetn)
      !commit |=> $stable(firstRowAddress) && $stable(lastRowAddress)
        && $stable(firstColumnAddress) && $stable(lastColumnAddress)
        && $stable(frameGap) && $stable(lineGapHigh) && $stable(lineGapLow);
  endproperty
  a_noMix: assert property (p_noMix)
    else $error("window or gap changed between frame boundaries");

  // pending clears on a commit that no write overlaps
  property p_pending;
    @(posedge ref_clk) disable iff (!resetn)
      (commit && !anyCellWrite) |=> !settingsPending;
  endproperty
  a_pending: assert property (p_pending)
    else $error("pending flag not cleared by commit");

  property p_unmapped;
    @(posedge ref_clk) disable iff (!resetn)
      setupPhase && !mapped ##1 accessPhase |-> pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped address not flagged");

  property p_mappedNoErr;
    @(posedge ref_clk) disable iff (!resetn)
      setupPhase && mapped ##1 accessPhase |-> !pslverr;
  endproperty
  a_mappedNoErr: assert property (p_mappedNoErr)
    else $error("mapped access flagged as an error");

  // set wins: a write landing beside a commit is never lost
  property p_pendingSet;
    @(posedge ref_clk) disable iff (!resetn)
      anyCellWrite |=> settingsPending;
  endproperty
  a_pendingSet: assert property (p_pendingSet)
    else $error("pending flag not set by a write");

  // the applied mark trails each commit by exactly one cycle
  property p_applied;
    @(posedge ref_clk) disable iff (!resetn)
      commit |=> settingsApplied;
  endproperty
  a_applied: assert property (p_applied)
    else $error("applied mark missing after commit");

  property p_appliedOnce;
    @(posedge ref_clk) disable iff (!resetn)
      !commit |=> !settingsApplied;
  endproperty
  a_appliedOnce: assert property (p_appliedOnce)
    else $error("applied mark without a commit");

  // a frozen boundary is swallowed whole
  property p_frozenNoApply;
    @(posedge ref_clk) disable iff (!resetn)
      frameStart && freeze |=> !settingsApplied && $stable(frameGap);
  endproperty
  a_frozenNoApply: assert property (p_frozenNoApply)
    else $error("frozen frame boundary applied settings");

  property p_lineGapLow;
    @(posedge ref_clk) disable iff (!resetn)
      commit |=> lineGapLow == $past(holdVal[window_delay_pkg::S_LINE_LOW]);
  endproperty
  a_lineGapLow: assert property (p_lineGapLow)
    else $error("line gap low byte wrong after commit");

  // only byte lane 0 ever carries read data
  property p_prdataUpper;
    @(posedge ref_clk) disable iff (!resetn)
      (prdata >> W) == 32'h0000_0000;
  endproperty
  a_prdataUpper: assert property (p_prdataUpper)
    else $error("read data upper lanes not zero");

  // read data stands until the next read setup, so a slow master still sees it
  property p_prdataHeld;
    @(posedge ref_clk) disable iff (!resetn)
      !(setupPhase && !pwrite) |=> $stable(prdata);
  endproperty
  a_prdataHeld: assert property (p_prdataHeld)
    else $error("read data moved outside a read setup");

  property p_statusRead;
    @(posedge ref_clk) disable iff (!resetn)
      setupPhase && !pwrite && statusHit
      |=> prdata[window_delay_pkg::STATUS_PENDING_BIT] == $past(settingsPending)
        && prdata[window_delay_pkg::STATUS_FROZEN_BIT] == $past(freeze);
  endproperty
  a_statusRead: assert property (p_statusRead)
    else $error("status word read wrong");

  property p_freezeWrite;
    @(posedge ref_clk) disable iff (!resetn)
      writeStrobe && ctrlHit |=> freeze == $past(pwdata[window_delay_pkg::CTRL_FREEZE_BIT]);
  endproperty
  a_freezeWrite: assert property (p_freezeWrite)
    else $error("freeze bit did not take the write");

endmodule

/* hw/window_delay_pkg.sv */
// package: register map, reset values and field layout of the window and gap bank
// Functional notes
// - the row-start high register holds bits 10:3 of the first row address in all eight bits.
// - bits 5:3 of the row low-bits register hold bits 2:0 of the first row address.
// - the row-end high register at index 1A holds bits 10:3 of the last row address.
// - bits 2:0 of the row low-bits register hold bits 2:0 of the last row address.
// - the column-start high register at index 1C holds bits 10:3 of the first column address.
// - bit 5 of the column low-bits register holds bit 2 of the first column address.
// - bits 1:0 of the first column address are always zero, so it is a multiple of four.
// - the column-end high register at index 1D holds bits 10:3 of the last column address.
// - bits 2:0 of the column low-bits register hold bits 2:0 of the last column address.
// - the 15-bit frame gap is the high register over bits 6:0 of the low register.
// - the line-gap high register at index 22 holds bits 15:8 of the line gap.
// - every window and gap register is read/write with a holding copy apart from the active copy.
package window_delay_pkg;

  localparam int NUM_REGS = 10;
  localparam int REG_WIDTH = 8;
  localparam int APB_DATA_WIDTH = 32;

  // slot numbers of the buffered registers
  localparam int S_ROW_START = 0;
  localparam int S_ROW_END = 1;
  localparam int S_ROW_LOW = 2;
  localparam int S_COL_START = 3;
  localparam int S_COL_END = 4;
  localparam int S_COL_LOW = 5;
  localparam int S_FRAME_HIGH = 6;
  localparam int S_FRAME_LOW = 7;
  localparam int S_LINE_HIGH = 8;
  localparam int S_LINE_LOW = 9;

  // register indices; the byte address is four times the index
  localparam logic [7:0] IDX_ROW_START = 8'h19;
  localparam logic [7:0] IDX_ROW_END = 8'h1a;
  localparam logic [7:0] IDX_ROW_LOW = 8'h1b;
  localparam logic [7:0] IDX_COL_START = 8'h1c;
  localparam logic [7:0] IDX_COL_END = 8'h1d;
  localparam logic [7:0] IDX_COL_LOW = 8'h1e;
  localparam logic [7:0] IDX_FRAME_HIGH = 8'h20;
  localparam logic [7:0] IDX_FRAME_LOW = 8'h21;
  localparam logic [7:0] IDX_LINE_HIGH = 8'h22;
  localparam logic [7:0] IDX_LINE_LOW = 8'h23;
  localparam logic [7:0] IDX_UPDATE_CTRL = 8'h24;
  localparam logic [7:0] IDX_UPDATE_STATUS = 8'h25;

  localparam logic [7:0] REG_INDEX [NUM_REGS] = '{IDX_ROW_START, IDX_ROW_END,
    IDX_ROW_LOW, IDX_COL_START, IDX_COL_END, IDX_COL_LOW, IDX_FRAME_HIGH,
    IDX_FRAME_LOW, IDX_LINE_HIGH, IDX_LINE_LOW};
  localparam logic [7:0] REG_RESET [NUM_REGS] = '{8'h00, 8'h00, 8'h00, 8'h00,
    8'ha0, 8'h23, 8'h00, 8'h08, 8'h00, 8'h00};
  // stored bits; reserved bits are never kept and read as zero
  localparam logic [7:0] REG_KEEP [NUM_REGS] = '{8'hff, 8'hff, 8'h3f, 8'hff,
    8'hff, 8'h27, 8'hff, 8'h7f, 8'hff, 8'hff};

  // field layout
  localparam int ADDR_WIDTH = 11;
  localparam int LOW_BITS = 3;
  localparam int ROW_START_LOW_POS = 3;
  localparam int ROW_END_LOW_POS = 0;
  localparam int COL_START_LOW_POS = 5;
  localparam int COL_END_LOW_POS = 0;
  localparam logic [1:0] COL_START_FIXED = 2'h0;
  localparam int FRAME_GAP_WIDTH = 15;
  localparam int FRAME_LOW_BITS = 7;
  localparam logic [14:0] FRAME_GAP_MAX = 15'h7fff;
  localparam int CTRL_FREEZE_BIT = 0;
  localparam int STATUS_PENDING_BIT = 0;
  localparam int STATUS_FROZEN_BIT = 1;

  function automatic logic [9:0] byte_addr(input logic [7:0] idx);
    return {idx, 2'b00};
  endfunction

endpackage

/* hw/buffered_reg_cell.sv */
// module: one double-buffered register, holding copy plus active copy
module buffered_reg_cell #(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0,
  parameter logic [WIDTH-1:0] KEEP_MASK = '1
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic writeEn,
  input wire logic [WIDTH-1:0] writeData,
  input wire logic commit,
  output logic [WIDTH-1:0] holdValue,
  output logic [WIDTH-1:0] activeValue
);

  if (WIDTH < 1) begin : g_badWidth
    $error("buffered_reg_cell: WIDTH must be at least 1");
  end

  // holding copy takes software writes; reserved bits are dropped here
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      holdValue <= RESET_VALUE;
    end else if (writeEn) begin
      holdValue <= writeData & KEEP_MASK;
    end
  end

  // active copy only moves on commit, so readout never sees half an update
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      activeValue <= RESET_VALUE;
    end else if (commit) begin
      activeValue <= holdValue;
    end
  end

  property p_activeHeld;
    @(posedge ref_clk) disable iff (!resetn)
      !commit |=> activeValue == $past(activeValue);
  endproperty
  a_activeHeld: assert property (p_activeHeld)
    else $error("active copy changed without a commit");

  property p_holdWritten;
    @(posedge ref_clk) disable iff (!resetn)
      writeEn |=> holdValue == ($past(writeData) & KEEP_MASK);
  endproperty
  a_holdWritten: assert property (p_holdWritten)
    else $error("holding copy did not take the write");

endmodule

/* test/window_delay_regs_test.sv */
// self-checking bench for the window and gap register bank
module window_delay_regs_test;
  timeunit 1ns;
  timeprecision 100ps;

  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'hf;
  logic frameStart = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, settingsPending, settingsApplied;
  logic [10:0] firstRowAddress, lastRowAddress, firstColumnAddress, lastColumnAddress;
  logic [14:0] frameGap;
  logic [7:0] lineGapHigh, lineGapLow;
  logic [7:0] hold [10];
  logic [7:0] act [10];
  int miscompares = 0;
  int samplesChecked = 0;
  // reset values of the register table, in slot order
  localparam logic [7:0] RESET_TABLE [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'ha0, 8'h23,
    8'h00, 8'h08, 8'h00, 8'h00};

  window_delay_regs #(.PADDR_WIDTH(8)) dut (.ref_clk(ref_clk), .resetn(resetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .frameStart(frameStart), .firstRowAddress(firstRowAddress),
    .lastRowAddress(lastRowAddress), .firstColumnAddress(firstColumnAddress),
    .lastColumnAddress(lastColumnAddress), .frameGap(frameGap), .lineGapHigh(lineGapHigh),
    .lineGapLow(lineGapLow), .settingsPending(settingsPending),
    .settingsApplied(settingsApplied));

  // 200 MHz clock
  always #2.5 ref_clk = ~ref_clk;

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", samplesChecked, miscompares);
    if (miscompares == 0 && samplesChecked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [7:0] addr_of(input int i);
    return {window_delay_pkg::REG_INDEX[i][5:0], 2'b00};
  endfunction

  // active outputs as the field layout assembles them from the active copies
  function automatic logic [31:0] expect_out(input int k);
    case (k)
      0: return 32'({act[0], act[2][5:3]});
      1: return 32'({act[1], act[2][2:0]});
      2: return 32'({act[3], act[5][5], 2'b00});
      3: return 32'({act[4], act[5][2:0]});
      4: return 32'({act[6], act[7][6:0]});
      5: return 32'(act[8]);
      default: return 32'(act[9]);
    endcase
  endfunction

  // one apb transfer; data and error are taken at the edge that samples pready high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s, output logic [31:0] rd, output logic err);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      miscompares++;
      report_and_stop();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic check_outputs();
    check(32'(firstRowAddress), expect_out(0));
    check(32'(lastRowAddress), expect_out(1));
    check(32'(firstColumnAddress), expect_out(2));
    check(32'(lastColumnAddress), expect_out(3));
    check(32'(frameGap), expect_out(4));
    check(32'(lineGapHigh), expect_out(5));
    check(32'(lineGapLow), expect_out(6));
  endtask

  // reads return the holding copies
  task automatic read_all();
    logic [31:0] rd;
    logic err;
    for (int i = 0; i < 10; i++) begin
      apb(1'b0, addr_of(i), 32'h0000_0000, 4'hf, rd, err);
      check(rd, 32'(hold[i]));
      check(32'(err), 32'h0000_0000);
    end
  endtask

  task automatic frame_pulse(input logic frozen);
    @(posedge ref_clk);
    frameStart <= 1'b1;
    @(posedge ref_clk);
    frameStart <= 1'b0;
    if (!frozen) act = hold;
    @(negedge ref_clk);
    check(32'(settingsApplied), 32'(!frozen));
    if (!frozen) check(32'(settingsPending), 32'h0000_0000);
    check_outputs();
  endtask

  initial begin
    logic [31:0] d, rd;
    logic err;
    void'($urandom(73));
    hold = RESET_TABLE;
    act = hold;
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    @(negedge ref_clk);
    check_outputs();
    read_all();
    $display("test reset values done");
    // all ones, all zeros, then random bytes; a full byte pair never exceeds the 15-bit gap
    for (int r = 0; r < 6; r++) begin
      for (int i = 0; i < 10; i++) begin
        d = (r == 0) ? 32'hffff_ffff : (r == 1) ? 32'h0000_0000 : $urandom;
        apb(1'b1, addr_of(i), d, 4'hf, rd, err);
        hold[i] = d[7:0] & window_delay_pkg::REG_KEEP[i];
      end
      @(negedge ref_clk);
      check(32'(settingsPending), 32'h0000_0001);
      check_outputs();
      read_all();
      frame_pulse(1'b0);
      $display("test update round %0d done", r);
    end
    // refused accesses leave every holding copy alone
    apb(1'b0, 8'hc0, 32'h0000_0000, 4'hf, rd, err);
    check(32'(err), 32'h0000_0001);
    apb(1'b1, 8'h65, 32'h0000_00ff, 4'hf, rd, err);
    check(32'(err), 32'h0000_0001);
    apb(1'b1, addr_of(0), 32'h0000_005a, 4'he, rd, err);
    apb(1'b1, 8'h94, 32'h0000_00ff, 4'hf, rd, err);
    apb(1'b0, 8'h94, 32'h0000_0000, 4'hf, rd, err);
    check(rd, 32'h0000_0000);
    d = $urandom;
    apb(1'b1, addr_of(2), d, 4'hf, rd, err);
    hold[2] = d[7:0] & window_delay_pkg::REG_KEEP[2];
    apb(1'b0, addr_of(2), 32'h0000_0000, 4'hf, rd, err);
    check(rd, 32'(hold[2]));
    read_all();
    $display("test refused accesses done");
    // frozen: a frame boundary must not move anything
    apb(1'b1, 8'h90, 32'h0000_0001, 4'hf, rd, err);
    d = $urandom;
    apb(1'b1, addr_of(9), d, 4'hf, rd, err);
    hold[9] = d[7:0];
    apb(1'b0, 8'h94, 32'h0000_0000, 4'hf, rd, err);
    check(rd, 32'h0000_0003);
    frame_pulse(1'b1);
    apb(1'b1, 8'h90, 32'h0000_0000, 4'hf, rd, err);
    frame_pulse(1'b0);
    $display("test freeze done");
    report_and_stop();
  end
endmodule
